//--- hdl/adc_single_mode_control.sv
// converter control: registers, conversion sequencer, flags and requests
// assumes an analog front end that presents a settled code on conv_data_in
// in the cycle before conv_capture_out pulses; all inputs synchronous to clock_in
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - one conversion per trigger, repeated without trigger in continuous run, 8 or 12 bits
// - command mode bit picks 8 or 12 bits
// - reference: external plus five internal choices
// - differential bit selects difference or single input
// - amp enable bit, gain 1x to 16x
// - amp control resets to nonzero value
// - routing field shared by both mux registers
// - three requests: error, sample, result
// - trigger while busy sets trigger overrun, except in the last convert cycle with continuous run off
// - unread sample overwritten sets sample overrun
// - unread result overwritten sets result overrun
// - new sample sets sample ready
// - new result sets result ready
// - each source gated by own enable
// - write one clears a flag
// - reading sample or result clears ready
// - window modes above, below, inside, outside
// - thresholds and mode from their registers
// - source bit picks result or sample
// - window request routed by its source
// - window evaluated per conversion here
// - start event edge launches conversion
// - sample phase length plus half or one
module adc_single_mode_control #(
   parameter int CONV_CYC_12 = adc_ctrl_pkg::CONV_CYCLES_12,
   parameter int CONV_CYC_8 = adc_ctrl_pkg::CONV_CYCLES_8
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // trigger
   input wire logic start_event_in,
   // analog front end
   input wire logic [11:0] conv_data_in,
   output adc_ctrl_pkg::afe_cfg_s afe_cfg_out,
   output logic sampling_out,
   output logic conv_capture_out,
   // interrupt requests
   output logic irq_error_out,
   output logic irq_sample_out,
   output logic irq_result_out
);
   if (CONV_CYC_12 < 1 || CONV_CYC_12 > 255 || CONV_CYC_8 < 1 || CONV_CYC_8 > 255) begin : g_bad_cycles
      $error("conversion cycle counts must lie in 1..255");
   end

   // register storage
   adc_ctrl_pkg::afe_cfg_s cfg;
   logic [1:0] start_field;
   logic [3:0] ctrl_d;
   logic [7:0] sample_length_field;
   logic continuous_run_bit;
   logic [3:0] prescale;
   logic [adc_ctrl_pkg::IRQ_W-1:0] irq_en;
   logic [adc_ctrl_pkg::IRQ_W-1:0] irq_flag;
   logic [15:0] sample_value;
   logic [15:0] result_value;
   logic [15:0] win_low;
   logic [15:0] win_high;
   logic sample_unread;
   logic result_unread;
   logic imm_start;

   // bus state
   logic aw_have;
   logic w_have;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // sequencer state
   adc_ctrl_pkg::conv_state_e state;
   logic [9:0] half_cnt;
   logic [3:0] div_cnt;
   logic event_prev;

   // byte-lane merge for narrow registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (nw & m);
   endfunction : merge

   // write side decode
   wire wr_fire = aw_have & w_have & ~s_axi_bvalid_out;
   wire wr_cmd = wr_fire && aw_addr == adc_ctrl_pkg::OFF_COMMAND;
   wire wr_c = wr_fire && aw_addr == adc_ctrl_pkg::OFF_CTRL_C;
   wire wr_d = wr_fire && aw_addr == adc_ctrl_pkg::OFF_CTRL_D;
   wire wr_e = wr_fire && aw_addr == adc_ctrl_pkg::OFF_CTRL_E;
   wire wr_f = wr_fire && aw_addr == adc_ctrl_pkg::OFF_CTRL_F;
   wire wr_amp = wr_fire && aw_addr == adc_ctrl_pkg::OFF_AMP_CTRL;
   wire wr_pos = wr_fire && aw_addr == adc_ctrl_pkg::OFF_POS_MUX;
   wire wr_neg = wr_fire && aw_addr == adc_ctrl_pkg::OFF_NEG_MUX;
   wire wr_ien = wr_fire && aw_addr == adc_ctrl_pkg::OFF_IRQ_EN;
   wire wr_flag = wr_fire && aw_addr == adc_ctrl_pkg::OFF_IRQ_FLAG;
   wire wr_wlo = wr_fire && aw_addr == adc_ctrl_pkg::OFF_WIN_LOW;
   wire wr_whi = wr_fire && aw_addr == adc_ctrl_pkg::OFF_WIN_HIGH;
   wire wr_known = wr_cmd | wr_c | wr_d | wr_e | wr_f | wr_amp | wr_pos | wr_neg | wr_ien | wr_flag | wr_wlo
      | wr_whi | (wr_fire && (aw_addr == adc_ctrl_pkg::OFF_SAMPLE || aw_addr == adc_ctrl_pkg::OFF_RESULT
      || aw_addr == adc_ctrl_pkg::OFF_STATUS));

   // current register images
   wire [31:0] img_cmd = {28'h0, cfg.differential_select, start_field, cfg.mode_12bit};
   wire [31:0] img_c = {29'h0, cfg.reference_select_field};
   wire [31:0] img_d = {28'h0, ctrl_d};
   wire [31:0] img_e = {24'h0, sample_length_field};
   wire [31:0] img_f = {27'h0, prescale, continuous_run_bit};
   wire [31:0] img_amp = {28'h0, cfg.amp_gain, cfg.amp_enable};
   wire [31:0] img_pos = {24'h0, cfg.amp_routing_field, 1'b0, cfg.pos_input};
   wire [31:0] img_neg = {24'h0, cfg.amp_routing_field, 1'b0, cfg.neg_input};
   wire [31:0] img_ien = {26'h0, irq_en};
   wire [31:0] img_flag = {26'h0, irq_flag};
   wire [31:0] img_stat = {31'h0, state != adc_ctrl_pkg::ST_IDLE};

   wire [31:0] wm_cmd = merge(img_cmd, w_data, w_strb);
   wire [31:0] wm_c = merge(img_c, w_data, w_strb);
   wire [31:0] wm_d = merge(img_d, w_data, w_strb);
   wire [31:0] wm_e = merge(img_e, w_data, w_strb);
   wire [31:0] wm_f = merge(img_f, w_data, w_strb);
   // partial writes keep untouched lanes of the current image, which resets nonzero
   wire [31:0] wm_amp = merge(img_amp, w_data, w_strb);
   wire [31:0] wm_pos = merge(img_pos, w_data, w_strb);
   wire [31:0] wm_neg = merge(img_neg, w_data, w_strb);
   wire [31:0] wm_ien = merge(img_ien, w_data, w_strb);
   wire [31:0] wm_flag = merge(32'h0, w_data, w_strb);
   wire [31:0] wm_wlo = merge({16'h0, win_low}, w_data, w_strb);
   wire [31:0] wm_whi = merge({16'h0, win_high}, w_data, w_strb);
   wire [1:0] wm_start = wm_cmd[adc_ctrl_pkg::CMD_START_LSB +: 2];
   wire [2:0] wm_gain = (wm_amp[3:1] > adc_ctrl_pkg::GAIN_MAX) ? adc_ctrl_pkg::GAIN_MAX : wm_amp[3:1];
   // one routing store, written through either mux register
   wire [1:0] next_routing = wr_pos ? wm_pos[adc_ctrl_pkg::ROUTE_LSB +: 2] :
      wr_neg ? wm_neg[adc_ctrl_pkg::ROUTE_LSB +: 2] : cfg.amp_routing_field;

   // read side decode
   wire rd_fire = s_axi_arvalid_in & s_axi_arready_out;
   wire rd_sample = rd_fire && s_axi_araddr_in == adc_ctrl_pkg::OFF_SAMPLE;
   wire rd_result = rd_fire && s_axi_araddr_in == adc_ctrl_pkg::OFF_RESULT;
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr_in)
         adc_ctrl_pkg::OFF_COMMAND: rd_mux = img_cmd;
         adc_ctrl_pkg::OFF_CTRL_C: rd_mux = img_c;
         adc_ctrl_pkg::OFF_CTRL_D: rd_mux = img_d;
         adc_ctrl_pkg::OFF_CTRL_E: rd_mux = img_e;
         adc_ctrl_pkg::OFF_CTRL_F: rd_mux = img_f;
         adc_ctrl_pkg::OFF_AMP_CTRL: rd_mux = img_amp;
         adc_ctrl_pkg::OFF_POS_MUX: rd_mux = img_pos;
         adc_ctrl_pkg::OFF_NEG_MUX: rd_mux = img_neg;
         adc_ctrl_pkg::OFF_IRQ_EN: rd_mux = img_ien;
         adc_ctrl_pkg::OFF_IRQ_FLAG: rd_mux = img_flag;
         adc_ctrl_pkg::OFF_SAMPLE: rd_mux = {16'h0, sample_value};
         adc_ctrl_pkg::OFF_RESULT: rd_mux = {16'h0, result_value};
         adc_ctrl_pkg::OFF_WIN_LOW: rd_mux = {16'h0, win_low};
         adc_ctrl_pkg::OFF_WIN_HIGH: rd_mux = {16'h0, win_high};
         adc_ctrl_pkg::OFF_STATUS: rd_mux = img_stat;
         default: begin
            rd_mux = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // converter clock: half-period enable pulses from a divider
   wire half_tick = div_cnt == prescale;

   // triggers
   wire event_edge = start_event_in & ~event_prev;
   wire trig_event = start_field == adc_ctrl_pkg::START_EVENT && event_edge;
   wire trigger = imm_start | trig_event;
   wire idle = state == adc_ctrl_pkg::ST_IDLE;
   wire last_half = half_tick && half_cnt == 10'h001;
   wire conv_done = state == adc_ctrl_pkg::ST_CONVERT && last_half;
   // sample phase counted in half cycles: 2*len+1 amp off, 2*len+2 amp on
   wire [9:0] samp_halves = {1'b0, sample_length_field, 1'b0} + (cfg.amp_enable ? 10'h002 : 10'h001);
   wire [9:0] conv_halves = cfg.mode_12bit ? 10'(2 * CONV_CYC_12) : 10'(2 * CONV_CYC_8);
   // restart after completion needs no fresh trigger
   wire restart = conv_done & continuous_run_bit;
   wire launch = (idle & trigger) | restart;

   // code formatting: 8-bit mode keeps the top bits; differential codes are signed
   wire [7:0] code8 = conv_data_in[11:4];
   wire [15:0] code16 = cfg.mode_12bit ?
      {{4{cfg.differential_select & conv_data_in[11]}}, conv_data_in} :
      {{8{cfg.differential_select & code8[7]}}, code8};

   // window source: result holds the same value in single mode
   wire win_from_sample = ctrl_d[adc_ctrl_pkg::WIN_SRC_BIT];
   wire win_match;
   window_compare u_window (
      .mode_in(ctrl_d[2:0]),
      .signed_in(cfg.differential_select),
      .low_in(win_low),
      .high_in(win_high),
      .value_in(code16),
      .match_out(win_match)
   );

   // flag events; a set in the clearing cycle wins
   logic [adc_ctrl_pkg::IRQ_W-1:0] flag_set;
   logic [adc_ctrl_pkg::IRQ_W-1:0] flag_clr;
   always_comb begin
      flag_set = '0;
      flag_set[adc_ctrl_pkg::IRQ_TRIG_OVR] = trigger & ~idle & ~(conv_done & ~continuous_run_bit);
      flag_set[adc_ctrl_pkg::IRQ_SAMP_OVR] = conv_done & sample_unread;
      flag_set[adc_ctrl_pkg::IRQ_RES_OVR] = conv_done & result_unread;
      flag_set[adc_ctrl_pkg::IRQ_SAMP_RDY] = conv_done;
      flag_set[adc_ctrl_pkg::IRQ_RES_RDY] = conv_done;
      flag_set[adc_ctrl_pkg::IRQ_WIN] = conv_done & win_match;
      flag_clr = wr_flag ? wm_flag[adc_ctrl_pkg::IRQ_W-1:0] : '0;
      flag_clr[adc_ctrl_pkg::IRQ_SAMP_RDY] = flag_clr[adc_ctrl_pkg::IRQ_SAMP_RDY] | rd_sample;
      flag_clr[adc_ctrl_pkg::IRQ_RES_RDY] = flag_clr[adc_ctrl_pkg::IRQ_RES_RDY] | rd_result;
   end
   wire [adc_ctrl_pkg::IRQ_W-1:0] next_flag = (irq_flag & ~flag_clr) | flag_set;

   // requests, each gated by its enable
   wire [adc_ctrl_pkg::IRQ_W-1:0] act = next_flag & irq_en;
   wire win_act = act[adc_ctrl_pkg::IRQ_WIN];
   wire next_irq_err = act[adc_ctrl_pkg::IRQ_TRIG_OVR] | act[adc_ctrl_pkg::IRQ_SAMP_OVR]
      | act[adc_ctrl_pkg::IRQ_RES_OVR];
   wire next_irq_samp = act[adc_ctrl_pkg::IRQ_SAMP_RDY] | (win_act & win_from_sample);
   wire next_irq_res = act[adc_ctrl_pkg::IRQ_RES_RDY] | (win_act & ~win_from_sample);

   // AXI4-Lite slave
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= adc_ctrl_pkg::RESP_OKAY;
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0;
         s_axi_rresp_out <= adc_ctrl_pkg::RESP_OKAY;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid_in & s_axi_awready_out) begin
            aw_addr <= s_axi_awaddr_in;
            aw_have <= 1'b1;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in & s_axi_wready_out) begin
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
            w_have <= 1'b1;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_fire) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_known ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid_out & s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
         if (rd_fire) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_mux;
            s_axi_rresp_out <= rd_hit ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
         end
         if (s_axi_rvalid_out & s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg <= '{reference_select_field: adc_ctrl_pkg::REF_SUPPLY, amp_enable: 1'b0,
            amp_gain: adc_ctrl_pkg::AMP_CTRL_RST[3:1], default: '0};
         start_field <= adc_ctrl_pkg::START_STOP;
         imm_start <= 1'b0;
         ctrl_d <= 4'h0;
         sample_length_field <= 8'h00;
         continuous_run_bit <= 1'b0;
         prescale <= 4'h0;
         irq_en <= '0;
         win_low <= 16'h0;
         win_high <= 16'h0;
      end else begin
         imm_start <= wr_cmd && wm_start == adc_ctrl_pkg::START_IMMEDIATE;
         if (wr_cmd) begin
            cfg.mode_12bit <= wm_cmd[adc_ctrl_pkg::CMD_MODE_BIT];
            cfg.differential_select <= wm_cmd[adc_ctrl_pkg::CMD_DIFFERENTIAL_SELECT_BIT];
            start_field <= (wm_start == adc_ctrl_pkg::START_IMMEDIATE) ? adc_ctrl_pkg::START_STOP : wm_start;
         end
         if (wr_c && wm_c[2:0] <= adc_ctrl_pkg::REF_4V096) begin
            cfg.reference_select_field <= wm_c[2:0];
         end
         if (wr_amp) begin
            cfg.amp_enable <= wm_amp[0];
            cfg.amp_gain <= wm_gain;
         end
         if (wr_pos) begin
            cfg.pos_input <= wm_pos[4:0];
         end
         if (wr_neg) begin
            cfg.neg_input <= wm_neg[4:0];
         end
         cfg.amp_routing_field <= next_routing;
         if (wr_d) begin
            ctrl_d <= wm_d[3:0];
         end
         if (wr_e) begin
            sample_length_field <= wm_e[7:0];
         end
         if (wr_f) begin
            continuous_run_bit <= wm_f[0];
            prescale <= wm_f[4:1];
         end
         if (wr_ien) begin
            irq_en <= wm_ien[adc_ctrl_pkg::IRQ_W-1:0];
         end
         if (wr_wlo) begin
            win_low <= wm_wlo[15:0];
         end
         if (wr_whi) begin
            win_high <= wm_whi[15:0];
         end
      end
   end

   // conversion sequencer; config writes reach the front end at once, also mid-conversion
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= adc_ctrl_pkg::ST_IDLE;
         half_cnt <= 10'h000;
         div_cnt <= 4'h0;
         event_prev <= 1'b0;
         sampling_out <= 1'b0;
         conv_capture_out <= 1'b0;
      end else begin
         event_prev <= start_event_in;
         div_cnt <= (half_tick || launch) ? 4'h0 : div_cnt + 4'h1;
         conv_capture_out <= conv_done;
         if (launch) begin
            state <= adc_ctrl_pkg::ST_SAMPLE;
            half_cnt <= samp_halves;
            sampling_out <= 1'b1;
         end else if (conv_done) begin
            state <= adc_ctrl_pkg::ST_IDLE;
         end else if (state == adc_ctrl_pkg::ST_SAMPLE && last_half) begin
            state <= adc_ctrl_pkg::ST_CONVERT;
            half_cnt <= conv_halves;
            sampling_out <= 1'b0;
         end else if (half_tick && state != adc_ctrl_pkg::ST_IDLE) begin
            half_cnt <= half_cnt - 10'h001;
         end
      end
   end

   // data registers, flags and requests
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sample_value <= 16'h0;
         result_value <= 16'h0;
         sample_unread <= 1'b0;
         result_unread <= 1'b0;
         irq_flag <= '0;
         irq_error_out <= 1'b0;
         irq_sample_out <= 1'b0;
         irq_result_out <= 1'b0;
      end else begin
         irq_flag <= next_flag;
         irq_error_out <= next_irq_err;
         irq_sample_out <= next_irq_samp;
         irq_result_out <= next_irq_res;
         sample_unread <= conv_done | (sample_unread & ~rd_sample);
         result_unread <= conv_done | (result_unread & ~rd_result);
         if (conv_done) begin
            sample_value <= code16;
            result_value <= code16;
         end
      end
   end

   assign afe_cfg_out = cfg;
endmodule : adc_single_mode_control

//--- hdl/adc_ctrl_pkg.sv
// constants, field layout and carrier types of the converter control block
// assumes a 32-bit AXI4-Lite register port, byte offsets below
package adc_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_COMMAND = 8'h00;
   localparam logic [7:0] OFF_CTRL_C = 8'h04;
   localparam logic [7:0] OFF_CTRL_D = 8'h08;
   localparam logic [7:0] OFF_CTRL_E = 8'h0c;
   localparam logic [7:0] OFF_CTRL_F = 8'h10;
   localparam logic [7:0] OFF_AMP_CTRL = 8'h14;
   localparam logic [7:0] OFF_POS_MUX = 8'h18;
   localparam logic [7:0] OFF_NEG_MUX = 8'h1c;
   localparam logic [7:0] OFF_IRQ_EN = 8'h20;
   localparam logic [7:0] OFF_IRQ_FLAG = 8'h24;
   localparam logic [7:0] OFF_SAMPLE = 8'h28;
   localparam logic [7:0] OFF_RESULT = 8'h2c;
   localparam logic [7:0] OFF_WIN_LOW = 8'h30;
   localparam logic [7:0] OFF_WIN_HIGH = 8'h34;
   localparam logic [7:0] OFF_STATUS = 8'h38;
   // command fields
   localparam int CMD_MODE_BIT = 0;
   localparam int CMD_START_LSB = 1;
   localparam int CMD_DIFFERENTIAL_SELECT_BIT = 3;
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_IMMEDIATE = 2'h1;
   localparam logic [1:0] START_EVENT = 2'h2;
   // reference choices
   localparam logic [2:0] REF_SUPPLY = 3'h0;
   localparam logic [2:0] REF_EXTERNAL = 3'h1;
   localparam logic [2:0] REF_1V024 = 3'h2;
   localparam logic [2:0] REF_2V048 = 3'h3;
   localparam logic [2:0] REF_2V500 = 3'h4;
   localparam logic [2:0] REF_4V096 = 3'h5;
   // window modes; control d bits [2:0] mode, bit 3 source
   localparam logic [2:0] WIN_NONE = 3'h0;
   localparam logic [2:0] WIN_BELOW = 3'h1;
   localparam logic [2:0] WIN_ABOVE = 3'h2;
   localparam logic [2:0] WIN_INSIDE = 3'h3;
   localparam logic [2:0] WIN_OUTSIDE = 3'h4;
   localparam int WIN_SRC_BIT = 3;
   // amplifier control: bit 0 enable, bits [3:1] gain code 0..4 = 1x..16x
   localparam logic [2:0] GAIN_MAX = 3'h4;
   localparam logic [3:0] AMP_CTRL_RST = 4'h2;
   // mux registers: [4:0] input, [7:6] shared routing
   localparam int ROUTE_LSB = 6;
   // interrupt flag and enable positions
   localparam int IRQ_RES_RDY = 0;
   localparam int IRQ_SAMP_RDY = 1;
   localparam int IRQ_WIN = 2;
   localparam int IRQ_RES_OVR = 3;
   localparam int IRQ_SAMP_OVR = 4;
   localparam int IRQ_TRIG_OVR = 5;
   localparam int IRQ_W = 6;
   // converter timing in converter clock cycles
   localparam int CONV_CYCLES_12 = 13;
   localparam int CONV_CYCLES_8 = 9;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b100
   } conv_state_e;

   // configuration driven to the analog front end
   typedef struct packed {
      logic [2:0] reference_select_field;
      logic differential_select;
      logic [4:0] pos_input;
      logic [4:0] neg_input;
      logic [1:0] amp_routing_field;
      logic amp_enable;
      logic [2:0] amp_gain;
      logic mode_12bit;
   } afe_cfg_s;
endpackage : adc_ctrl_pkg

//--- hdl/window_compare.sv
// window comparator: threshold test of one 16-bit value
// assumes thresholds and value share one encoding, signed when asked
`timescale 1ns/1ps
module window_compare (
   // setup
   input wire logic [2:0] mode_in,
   input wire logic signed_in,
   input wire logic [15:0] low_in,
   input wire logic [15:0] high_in,
   // value under test
   input wire logic [15:0] value_in,
   output logic match_out
);
   // flipping the sign bit turns a signed order into an unsigned one
   wire [15:0] bias = {signed_in, 15'h0000};
   wire [15:0] v = value_in ^ bias;
   wire [15:0] lo = low_in ^ bias;
   wire [15:0] hi = high_in ^ bias;
   wire below_lo = v < lo;
   wire above_hi = v > hi;
   wire above_lo = v > lo;
   wire below_hi = v < hi;

   always_comb begin
      case (mode_in)
         adc_ctrl_pkg::WIN_BELOW: match_out = below_lo;
         adc_ctrl_pkg::WIN_ABOVE: match_out = above_hi;
         adc_ctrl_pkg::WIN_INSIDE: match_out = above_lo & below_hi;
         adc_ctrl_pkg::WIN_OUTSIDE: match_out = below_lo | above_hi;
         default: match_out = 1'b0;
      endcase
   end
endmodule : window_compare

//--- sim/adc_ctrl_checker.sv
// port assertions for the converter control block
// assumes a bind into the design top, one clock domain
`timescale 1ns/1ps
module adc_ctrl_checker (
   // clock, reset and bus answers
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_rvalid_out,
   // converter and requests
   input wire adc_ctrl_pkg::afe_cfg_s afe_cfg_out,
   input wire logic conv_capture_out,
   input wire logic irq_error_out,
   input wire logic irq_sample_out,
   input wire logic irq_result_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   // a request falls only after a register write or a data read
   // requests move at the same edge as the bus answer, so the answer is seen in the same cycle as the change
   sequence drop_cause; s_axi_bvalid_out || s_axi_rvalid_out; endsequence
   sequence rise_cause; conv_capture_out || s_axi_bvalid_out; endsequence
   AST_RES_DROP: assert property ($fell(irq_result_out) |-> drop_cause) else $error("result drop");
   AST_SMP_DROP: assert property ($fell(irq_sample_out) |-> drop_cause) else $error("sample drop");
   AST_ERR_DROP: assert property ($fell(irq_error_out) |-> s_axi_bvalid_out) else $error("error drop");
   AST_RES_RISE: assert property ($rose(irq_result_out) |-> rise_cause) else $error("result rise");
   AST_SMP_RISE: assert property ($rose(irq_sample_out) |-> rise_cause) else $error("sample rise");
   AST_GAIN_RST: assert property ($past(sys_rst_in) |-> afe_cfg_out.amp_gain == adc_ctrl_pkg::AMP_CTRL_RST[3:1])
      else $error("gain reset");
   AST_REF_OK: assert property (afe_cfg_out.reference_select_field <= adc_ctrl_pkg::REF_4V096)
      else $error("reference");
   AST_GAIN_OK: assert property (afe_cfg_out.amp_gain <= adc_ctrl_pkg::GAIN_MAX) else $error("gain");
   AST_ONE_CAP: assert property (conv_capture_out |=> !conv_capture_out [*8]) else $error("capture");
endmodule : adc_ctrl_checker
bind adc_single_mode_control adc_ctrl_checker chk (.*);

//--- sim/tb_top.sv
// self-checking bench: registers, conversions, flags, window
// assumes package, design and checker compiled before it
`timescale 1ns/1ps
module tb_top;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("wrong value at %0t: %h", $time, g); end end
   logic clock_in = 1'b0, sys_rst_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_arvalid_in = 1'b0;
   logic s_axi_bready_in = 1'b1, s_axi_rready_in = 1'b1, start_event_in = 1'b0;
   logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
   logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, d;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic [11:0] conv_data_in = 12'h0;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, sampling_out;
   logic conv_capture_out, irq_error_out, irq_sample_out, irq_result_out;
   adc_ctrl_pkg::afe_cfg_s afe_cfg_out;
   int miscompares = 0, n_compared = 0;
   adc_single_mode_control dut (.*);
   initial begin
      forever #2 clock_in = ~clock_in;
   end
   // ready lines held high: every answer is taken at once
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= v;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (!s_axi_bvalid_out);
      r = s_axi_bresp_out;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      do @(posedge clock_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 1'b0;
      do @(posedge clock_in); while (!s_axi_rvalid_out);
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
   endtask : rd
   task automatic wait_smp;
      int k;
      for (k = 0; k < 500 && irq_sample_out !== 1'b1; k++) @(posedge clock_in);
      `CHK(irq_sample_out, 1'b1)
      `CHK(conv_capture_out, 1'b1)
   endtask : wait_smp
   task automatic t_regs;
      rd(8'h14);
      `CHK(d, 32'h2)
      wr(8'h14, 32'hf);
      `CHK(r, adc_ctrl_pkg::RESP_OKAY)
      rd(8'h14);
      `CHK(d, 32'h9)
      `CHK({afe_cfg_out.amp_gain, afe_cfg_out.amp_enable}, 4'h9)
      wr(8'h18, 32'h80); // routing set with the amplifier on
      rd(8'h1c);
      `CHK(d, 32'h80)
      `CHK(afe_cfg_out.amp_routing_field, 2'h2)
      wr(8'h04, 32'h3);
      wr(8'h04, 32'h7);
      `CHK(afe_cfg_out.reference_select_field, adc_ctrl_pkg::REF_2V048)
      wr(8'h3c, 32'h1);
      `CHK(r, adc_ctrl_pkg::RESP_SLVERR)
      rd(8'h3c);
      `CHK(r, adc_ctrl_pkg::RESP_SLVERR)
   endtask : t_regs
   task automatic t_conv;
      wr(8'h20, 32'h3f);
      conv_data_in <= 12'habc;
      wr(8'h00, 32'h3);
      wait_smp();
      `CHK(irq_result_out, 1'b1)
      rd(8'h28);
      `CHK(d, 32'habc)
      rd(8'h24);
      `CHK(d, 32'h1)
      wr(8'h00, 32'h2);
      wait_smp(); // reconfigure only once the sample is in
      rd(8'h2c);
      `CHK(d, 32'hab)
      rd(8'h24);
      `CHK(d, 32'ha)
      `CHK(irq_error_out, 1'b1)
      wr(8'h24, 32'h3f);
      // second launch lands while the first is still converting
      wr(8'h00, 32'h3);
      wr(8'h00, 32'h3);
      wait_smp();
      rd(8'h24);
      `CHK(d, 32'h33)
      wr(8'h24, 32'h3f);
      rd(8'h24);
      `CHK(d, 32'h0)
   endtask : t_conv
   task automatic t_event;
      wr(8'h30, 32'h10);
      wr(8'h34, 32'h80);
      wr(8'h08, 32'hb);
      conv_data_in <= 12'h5a0;
      wr(8'h00, 32'h4);
      start_event_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      `CHK(sampling_out, 1'b1)
      start_event_in <= 1'b0;
      wait_smp();
      rd(8'h24);
      `CHK(d[2], 1'b1)
      rd(8'h28);
      `CHK(d, 32'h5a)
   endtask : t_event
   // continuous run with a slowed converter clock, differential 12-bit codes
   task automatic t_free;
      wr(8'h24, 32'h3f);
      conv_data_in <= 12'habc;
      wr(8'h10, 32'h3);
      wr(8'h00, 32'hb);
      wait_smp();
      rd(8'h28);
      `CHK(d, 32'hfabc)
      wait_smp();
      wr(8'h10, 32'h2); // stop continuous run before anything else
      wr(8'h24, 32'h3f);
      wait_smp();
      wr(8'h24, 32'h3f);
      repeat (100) @(posedge clock_in);
      `CHK(irq_sample_out, 1'b0)
   endtask : t_free
   task automatic end_of_test;
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (4) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      t_regs();
      t_conv();
      t_event();
      t_free();
      end_of_test();
   end
   // whole run is well under a thousand cycles
   initial begin
      #20000;
      miscompares++;
      end_of_test();
   end
endmodule : tb_top
